// ==== hdl/ssp_slave.sv ====
// ssp synchronous slave serial port with apb register access
//
// The address map and register access over APB are this design's own decisions.
`include "ssp_cfg.svh"
`default_nettype none
module ssp_slave (
  // apb
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // serial pins
  input  wire logic                 serial_clock_in,
  input  wire logic                 serial_data_in,
  output ssp_pkg::ssp_pin_t         serial_data_pin,
  // core status
  input  wire logic                 core_sleep,
  output logic                      core_wake,
  output logic                      core_irq
);
  import ssp_pkg::*;

  typedef struct packed {
    logic [2:0]    ck_sync;
    logic [2:0]    dt_sync;
    logic          ck_lvl;
    logic [7:0]    baud;
    logic [7:0]    rcsta;
    logic [7:0]    ratel;
    logic [7:0]    rateh;
    logic [7:0]    txsta;
    logic [3:0]    irq_en;
    logic          tx_full;
    logic [8:0]    tx_hold;
    logic [8:0]    transmit_shift_register;
    logic [3:0]    tx_cnt;
    ssp_tx_state_t tx_st;
    logic          txif;
    logic [8:0]    receive_shift_register;
    logic [3:0]    rx_cnt;
    logic [8:0]    rx_word;
    logic          rcif;
    logic          oerr;
    logic          dout;
    logic [31:0]   rdata;
  } ssp_state_t;

  ssp_state_t st_ff;
  ssp_state_t nxt_st;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] ssp_bits(input logic nine);
    ssp_bits = nine ? 4'h9 : 4'h8;
  endfunction

  function automatic logic ssp_hit(input logic [11:0] a, input logic [11:0] off);
    ssp_hit = (a == off);
  endfunction

  logic port_enable_bit;
  logic slave;
  logic tx_mode;
  logic rx_mode;
  logic ck_rise;
  logic ck_fall;
  logic wr_acc;
  logic rd_acc;
  logic tx_empty;
  logic unmapped;

  always_comb begin
    port_enable_bit     = st_ff.rcsta[`SSP_RC_PORT_ENABLE_BIT];
    // slave only when master select is clear
    slave    = port_enable_bit && st_ff.txsta[`SSP_TX_SYNC] && !st_ff.txsta[`SSP_TX_CLOCK_MASTER_SELECT];
    // single receive enable plays no part in slave mode
    rx_mode  = slave && st_ff.rcsta[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE];
    tx_mode  = slave && !rx_mode && st_ff.txsta[`SSP_TX_TRANSMIT_ENABLE_BIT];
    // edges counted once second and third stage agree
    ck_rise  = (st_ff.ck_sync[2:1] == 2'b11) && !st_ff.ck_lvl;
    ck_fall  = (st_ff.ck_sync[2:1] == 2'b00) && st_ff.ck_lvl;
    wr_acc   = psel && penable && pwrite;
    rd_acc   = psel && !penable && !pwrite;
    tx_empty = (st_ff.tx_st == SSP_IDLE) && !st_ff.tx_full;
    unmapped = paddr > `SSP_OFF_IRQ || paddr[1:0] != 2'b00;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ck_sync = {st_ff.ck_sync[1:0], serial_clock_in};
    nxt_st.dt_sync = {st_ff.dt_sync[1:0], serial_data_in};
    if (st_ff.ck_sync[2] == st_ff.ck_sync[1]) begin
      nxt_st.ck_lvl = st_ff.ck_sync[2];
    end

    // register writes
    if (wr_acc && !unmapped) begin
      if (ssp_hit(paddr, `SSP_OFF_BAUD)) begin
        nxt_st.baud = pwdata[7:0];
      end else if (ssp_hit(paddr, `SSP_OFF_RCSTA)) begin
        nxt_st.rcsta = pwdata[7:0];
      end else if (ssp_hit(paddr, `SSP_OFF_RATEL)) begin
        nxt_st.ratel = pwdata[7:0];
      end else if (ssp_hit(paddr, `SSP_OFF_RATEH)) begin
        nxt_st.rateh = pwdata[7:0];
      end else if (ssp_hit(paddr, `SSP_OFF_TXSTA)) begin
        nxt_st.txsta = pwdata[7:0];
      end else if (ssp_hit(paddr, `SSP_OFF_IRQ)) begin
        nxt_st.irq_en = pwdata[3:0];
      end else if (ssp_hit(paddr, `SSP_OFF_TXHOLD) && !st_ff.tx_full) begin
        // ninth bit taken from the field written beforehand
        nxt_st.tx_hold = {st_ff.txsta[`SSP_TX_TRANSMIT_NINTH_BIT], pwdata[7:0]};
        nxt_st.tx_full = 1'b1;
        nxt_st.txif    = 1'b0;
      end
    end

    // reading the receive register consumes the flag
    if (rd_acc && ssp_hit(paddr, `SSP_OFF_RXFIFO)) begin
      nxt_st.rcif = 1'b0;
    end

    // transmit engine, external clock only
    case (st_ff.tx_st)
      SSP_IDLE: begin
        if (tx_mode && st_ff.tx_full) begin
          nxt_st.tx_st = SSP_LOAD;
        end
      end
      SSP_LOAD: begin
        nxt_st.transmit_shift_register     = st_ff.tx_hold;
        nxt_st.tx_full = 1'b0;
        nxt_st.tx_cnt  = ssp_bits(st_ff.txsta[`SSP_TX_TX9]);
        nxt_st.dout    = st_ff.tx_hold[0];
        nxt_st.txif    = 1'b1;
        nxt_st.tx_st   = SSP_SHIFT;
      end
      SSP_SHIFT: begin
        // holding word waits while shifting
        if (ck_fall && st_ff.tx_cnt != 4'h9 && st_ff.tx_cnt != ssp_bits(st_ff.txsta[`SSP_TX_TX9]))
        begin
          nxt_st.dout = st_ff.transmit_shift_register[0];
        end
        if (ck_rise) begin
          nxt_st.transmit_shift_register    = {1'b0, st_ff.transmit_shift_register[8:1]};
          nxt_st.tx_cnt = st_ff.tx_cnt - 4'h1;
          if (ck_rise && st_ff.tx_cnt == 4'h1) begin
            nxt_st.tx_st = st_ff.tx_full ? SSP_LOAD : SSP_IDLE;
          end
        end
        if (ck_fall) begin
          nxt_st.dout = st_ff.transmit_shift_register[0];
        end
      end
      default: nxt_st.tx_st = SSP_IDLE;
    endcase
    // flag held clear while a word is pending; a load that empties the holding
    // register lets the flag set
    if (nxt_st.tx_full) begin
      nxt_st.txif = 1'b0;
    end

    // receive engine, runs in sleep too
    if (rx_mode && ck_fall) begin
      nxt_st.receive_shift_register = st_ff.rcsta[`SSP_RC_RX9] ? {st_ff.dt_sync[2], st_ff.receive_shift_register[8:1]}
                                            : {1'b0, st_ff.dt_sync[2], st_ff.receive_shift_register[7:1]};
      nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
      if (st_ff.rx_cnt + 4'h1 == ssp_bits(st_ff.rcsta[`SSP_RC_RX9])) begin
        nxt_st.rx_cnt = 4'h0;
        if (st_ff.rcif) begin
          nxt_st.oerr = 1'b1;
        end else begin
          // completed word into receive register
          nxt_st.rx_word = st_ff.rcsta[`SSP_RC_RX9] ? {st_ff.dt_sync[2], st_ff.receive_shift_register[8:1]}
                                                    : {1'b0, st_ff.dt_sync[2], st_ff.receive_shift_register[7:1]};
          nxt_st.rcif    = 1'b1;
        end
      end
    end
    if (!rx_mode) begin
      nxt_st.rx_cnt = 4'h0;
      nxt_st.oerr   = 1'b0;
    end

    // port disable resets the serial side
    if (!port_enable_bit) begin
      nxt_st.tx_st   = SSP_IDLE;
      nxt_st.tx_full = 1'b0;
      nxt_st.tx_cnt  = 4'h0;
      nxt_st.txif    = 1'b0;
      nxt_st.rcif    = 1'b0;
      nxt_st.oerr    = 1'b0;
      nxt_st.rx_cnt  = 4'h0;
    end

    // read data, captured in setup and held until the next read
    if (rd_acc) begin
      nxt_st.rdata = 32'h0000_0000;
      if (ssp_hit(paddr, `SSP_OFF_BAUD)) begin
        nxt_st.rdata[7:0] = st_ff.baud;
      end else if (ssp_hit(paddr, `SSP_OFF_RCSTA)) begin
        nxt_st.rdata[7:0] = {st_ff.rcsta[7:2], st_ff.oerr, st_ff.rx_word[8]};
      end else if (ssp_hit(paddr, `SSP_OFF_RATEL)) begin
        nxt_st.rdata[7:0] = st_ff.ratel;
      end else if (ssp_hit(paddr, `SSP_OFF_RATEH)) begin
        nxt_st.rdata[7:0] = st_ff.rateh;
      end else if (ssp_hit(paddr, `SSP_OFF_TXSTA)) begin
        nxt_st.rdata[7:0] = {st_ff.txsta[7:2], tx_empty, st_ff.txsta[0]};
      end else if (ssp_hit(paddr, `SSP_OFF_RXFIFO)) begin
        nxt_st.rdata[7:0] = st_ff.rx_word[7:0];
      end else if (ssp_hit(paddr, `SSP_OFF_IRQ)) begin
        nxt_st.rdata[5:0] = {st_ff.rcif, st_ff.txif, st_ff.irq_en};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff       <= '0;
      st_ff.txsta <= `SSP_RST_TXSTA;
      st_ff.tx_st <= SSP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic tx_evt;
  logic rx_evt;
  always_comb begin
    pready  = 1'b1;
    pslverr = psel && penable && unmapped;
    prdata  = st_ff.rdata;
    serial_data_pin.data_out  = st_ff.dout;
    serial_data_pin.data_oe_n = !(tx_mode && st_ff.tx_st != SSP_IDLE);
    tx_evt = st_ff.txif && st_ff.irq_en[`SSP_IR_TXIE];
    rx_evt = st_ff.rcif && st_ff.irq_en[`SSP_IR_RCIE];
    // wake on enabled flags
    core_wake = (tx_evt && st_ff.irq_en[`SSP_IR_PEIE]) || rx_evt;
    // divert only with global enable too
    core_irq  = core_wake && st_ff.irq_en[`SSP_IR_GIE] && (core_sleep || 1'b1);
  end
endmodule // ssp_slave
`default_nettype wire

// ==== hdl/ssp_cfg.svh ====
// ssp register offsets, field positions and reset values
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_OFF_BAUD   12'h000
`define SSP_OFF_RCSTA  12'h004
`define SSP_OFF_RATEL  12'h008
`define SSP_OFF_RATEH  12'h00C
`define SSP_OFF_TXHOLD 12'h010
`define SSP_OFF_TXSTA  12'h014
`define SSP_OFF_RXFIFO 12'h018
`define SSP_OFF_IRQ    12'h01C
// receive status/control fields
`define SSP_RC_PORT_ENABLE_BIT  7
`define SSP_RC_RX9   6
`define SSP_RC_SINGLE_RECEIVE_ENABLE  5
`define SSP_RC_CONTINUOUS_RECEIVE_ENABLE  4
`define SSP_RC_OERR  1
`define SSP_RC_RECEIVED_NINTH_BIT  0
// transmit status/control fields
`define SSP_TX_CLOCK_MASTER_SELECT  7
`define SSP_TX_TX9   6
`define SSP_TX_TRANSMIT_ENABLE_BIT  5
`define SSP_TX_SYNC  4
`define SSP_TX_SHIFT_EMPTY_STATUS  1
`define SSP_TX_TRANSMIT_NINTH_BIT  0
// interrupt control fields
`define SSP_IR_GIE   0
`define SSP_IR_PEIE  1
`define SSP_IR_TXIE  2
`define SSP_IR_RCIE  3
`define SSP_IR_TXIF  4
`define SSP_IR_RCIF  5
`define SSP_RST_TXSTA 8'h02
`define SSP_RST_BYTE  8'h00
`endif

// ==== hdl/ssp_pkg.sv ====
// ssp package: shared types
`default_nettype none
package ssp_pkg;
  typedef struct packed {
    logic        paddr_ok;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ssp_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ssp_apb_rsp_t;
  typedef struct packed {
    logic data_out;
    logic data_oe_n;
  } ssp_pin_t;
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_SHIFT = 3'b010,
    SSP_LOAD = 3'b100
  } ssp_tx_state_t;
endpackage
`default_nettype wire

// ==== dv/ssp_slave_checker.sv ====
// assertion checker for the slave serial port, bound to its ports
`include "ssp_cfg.svh"
`default_nettype none
module ssp_slave_checker (
  // apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  // serial and core
  input wire logic              serial_clock_in,
  input wire logic              serial_data_in,
  input wire ssp_pkg::ssp_pin_t serial_data_pin,
  input wire logic              core_sleep,
  input wire logic              core_wake,
  input wire logic              core_irq
);
  import ssp_pkg::*;
  logic [7:0] rc_ff, tx_ff, ie_ff;
  logic       wr;
  assign wr = psel && penable && pwrite;
  // shadows of the control registers as software wrote them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_ff <= 8'h00;
      tx_ff <= 8'h00;
      ie_ff <= 8'h00;
    end else if (wr) begin
      if (paddr == `SSP_OFF_RCSTA) rc_ff <= pwdata[7:0];
      if (paddr == `SSP_OFF_TXSTA) tx_ff <= pwdata[7:0];
      if (paddr == `SSP_OFF_IRQ) ie_ff <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence hold_write;
    wr && paddr == `SSP_OFF_TXHOLD && rc_ff[`SSP_RC_PORT_ENABLE_BIT] && !rc_ff[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] &&
      tx_ff[`SSP_TX_TRANSMIT_ENABLE_BIT] && tx_ff[`SSP_TX_SYNC] && !tx_ff[`SSP_TX_CLOCK_MASTER_SELECT] &&
      serial_data_pin.data_oe_n;
  endsequence
  sequence shifter_on;
    ##[1:4] !serial_data_pin.data_oe_n;
  endsequence
  a_ready_zero: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (psel && penable && (paddr > `SSP_OFF_IRQ ||
    paddr[1:0] != 2'b00) |-> pslverr) else $error("no error on unmapped access");
  a_err_mapped: assert property (psel && penable && paddr <= `SSP_OFF_IRQ &&
    paddr[1:0] == 2'b00 |-> !pslverr) else $error("error on mapped access");
  a_irq_global: assert property (core_irq |-> ie_ff[`SSP_IR_GIE] && core_wake)
    else $error("irq without global enable");
  a_wake_enable: assert property (core_wake |-> ie_ff[`SSP_IR_RCIE] ||
    (ie_ff[`SSP_IR_PEIE] && ie_ff[`SSP_IR_TXIE])) else $error("wake without enable");
  a_recv_quiet: assert property ((rc_ff[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE])[*2] |->
    serial_data_pin.data_oe_n) else $error("pin driven while receiving");
  a_tx_start: assert property (hold_write |-> shifter_on)
    else $error("holding write did not start shifting");
  a_port_off: assert property (wr && paddr == `SSP_OFF_RCSTA &&
    !pwdata[`SSP_RC_PORT_ENABLE_BIT] |=> ##1 serial_data_pin.data_oe_n && !core_wake)
    else $error("port disable did not reset");
  a_irq_off: assert property (wr && paddr == `SSP_OFF_IRQ && pwdata[3:0] == 4'h0
    |=> !core_wake && !core_irq) else $error("wake with enables cleared");
endmodule // ssp_slave_checker
bind ssp_slave ssp_slave_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
  .serial_data_pin(serial_data_pin), .core_sleep(core_sleep), .core_wake(core_wake),
  .core_irq(core_irq)
);
`default_nettype wire

// ==== dv/ssp_master_model.sv ====
// external synchronous master: makes the shift clock and drives or samples data
`default_nettype none
module ssp_master_model (
  // clock
  input  wire logic pclk,
  // link
  input  wire logic line,
  output logic      link_clk,
  output logic      link_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_ff = 1'b0;
  logic bit_ff = 1'b0;
  logic tog_ff = 1'b0;
  initial link_clk = 1'b0;
  always @(posedge pclk) tog_ff <= ~tog_ff;
  // released line changes every cycle so a stale bit never passes
  assign link_drv = drv_ff ? bit_ff : tog_ff;
  // one 400 ns clock per bit, lsb first; clock stands low outside frames
  task automatic frame(input int nbits, input logic [8:0] send, output logic [8:0] got);
    got = 9'h000;
    for (int i = 0; i < nbits; i++) begin
      @(posedge pclk);
      link_clk <= 1'b1;
      @(posedge pclk);
      drv_ff <= 1'b1;
      bit_ff <= send[i];
      repeat (3) @(posedge pclk);
      got[i] = line;
      link_clk <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
    drv_ff <= 1'b0;
  endtask
endmodule // ssp_master_model
`default_nettype wire

// ==== dv/ssp_slave_tb.sv ====
// self-checking bench for the slave serial port
`include "ssp_cfg.svh"
`default_nettype none
module ssp_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, core_sleep, pready, pslverr;
  logic        core_wake, core_irq, link_clk, link_drv, line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prd, seed;
  logic [7:0]  b[5];
  logic [8:0]  got;
  ssp_pin_t    pin;
  int          n_fail, n_checks;
  logic [31:0] exp_q[$], act_q[$];
  assign line = pin.data_oe_n ? link_drv : pin.data_out;
  ssp_slave i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .serial_clock_in(link_clk), .serial_data_in(line), .serial_data_pin(pin),
    .core_sleep(core_sleep), .core_wake(core_wake), .core_irq(core_irq)
  );
  ssp_master_model i_mst (.pclk(pclk), .line(line), .link_clk(link_clk), .link_drv(link_drv));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    prd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      results();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
    act_q.push_back(prd);
  endtask
  task automatic flags(input logic [1:0] e);
    exp_q.push_back({30'h0, e});
    @(negedge pclk);
    act_q.push_back({30'h0, core_wake, core_irq});
  endtask
  task automatic tx(input logic [8:0] e);
    exp_q.push_back({23'h0, e});
    i_mst.frame(9, 9'h000, got);
    act_q.push_back({23'h0, got});
    repeat (10) @(posedge pclk);
  endtask
  // monitor: pairs each result with the oldest note
  initial begin
    forever begin
      @(posedge pclk);
      while (act_q.size() > 0) check(exp_q.pop_front(), act_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    results();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, core_sleep} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    n_checks = 0;
    seed = 32'h32A232FF;
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      b[i] = seed[7:0];
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SSP_OFF_TXSTA, 32'h02);
    rd(`SSP_OFF_RCSTA, 32'h00);
    apb(1'b0, 12'h022, 32'h0);
    wr(`SSP_OFF_RCSTA, 32'h80);
    wr(`SSP_OFF_IRQ, 32'h07);
    wr(`SSP_OFF_TXSTA, 32'h71);
    wr(`SSP_OFF_TXHOLD, {24'h0, b[0]});
    wr(`SSP_OFF_TXSTA, 32'h70);
    core_sleep <= 1'b1;
    wr(`SSP_OFF_TXHOLD, {24'h0, b[1]});
    rd(`SSP_OFF_IRQ, 32'h07);
    rd(`SSP_OFF_TXSTA, 32'h70);
    tx({1'b1, b[0]});
    flags(2'b11);
    rd(`SSP_OFF_IRQ, 32'h17);
    tx({1'b0, b[1]});
    rd(`SSP_OFF_TXSTA, 32'h72);
    wr(`SSP_OFF_IRQ, 32'h06);
    flags(2'b10);
    wr(`SSP_OFF_IRQ, 32'h0A);
    wr(`SSP_OFF_RCSTA, 32'hF0);
    i_mst.frame(9, {1'b1, b[2]}, got);
    repeat (10) @(posedge pclk);
    flags(2'b10);
    rd(`SSP_OFF_RCSTA, 32'hF1);
    rd(`SSP_OFF_RXFIFO, {24'h0, b[2]});
    wr(`SSP_OFF_RCSTA, 32'hD0);
    i_mst.frame(9, {1'b0, b[3]}, got);
    i_mst.frame(9, {1'b0, b[4]}, got);
    repeat (10) @(posedge pclk);
    rd(`SSP_OFF_RCSTA, 32'hD2);
    rd(`SSP_OFF_RXFIFO, {24'h0, b[3]});
    wr(`SSP_OFF_RCSTA, 32'hC0);
    rd(`SSP_OFF_RCSTA, 32'hC0);
    wr(`SSP_OFF_RCSTA, 32'h00);
    wr(`SSP_OFF_IRQ, 32'h00);
    repeat (4) @(posedge pclk);
    results();
  end
endmodule // ssp_slave_tb
`default_nettype wire
